// *** core/mat_pkg.sv ***
// Shared constants, types and helper functions for the matrix engine datapath.
package mat_pkg;

  localparam int NUM_PE    = 16;
  localparam int NUM_REG   = 16;
  localparam int DATA_W    = 32;
  localparam int HALF_W    = 16;
  localparam int ACC_W     = 40;
  localparam int CC_W      = 4;
  localparam int MEM_W     = 512;
  localparam int DIM       = 4;
  localparam int MMUL_CYC  = 4;

  localparam logic [1:0]  MMUL_LAST = 2'h3;
  localparam logic [31:0] REG_RST   = 32'h0000_0000;
  localparam logic [39:0] ACC_RST   = 40'h00_0000_0000;
  localparam logic [3:0]  CC_RST    = 4'h0;

  localparam int CC_LT = 3;
  localparam int CC_EQ = 2;
  localparam int CC_GT = 1;
  localparam int CC_NE = 0;

  typedef enum logic [4:0] {
    OP_NOP    = 5'h00,
    OP_LOAD   = 5'h01,
    OP_STORE  = 5'h02,
    OP_ADD    = 5'h03,
    OP_SUB    = 5'h04,
    OP_AND    = 5'h05,
    OP_OR     = 5'h06,
    OP_XOR    = 5'h07,
    OP_CMP    = 5'h08,
    OP_MUL    = 5'h09,
    OP_MAC    = 5'h0A,
    OP_MSUB   = 5'h0B,
    OP_ACCMOV = 5'h0C,
    OP_TRANS  = 5'h0D,
    OP_SHIFT  = 5'h0E,
    OP_SHROW  = 5'h0F,
    OP_SHCOL  = 5'h10,
    OP_LOOKUP = 5'h11,
    OP_FOUR_REGISTER_BLOCK_INTERLEAVE = 5'h12,
    OP_MMUL   = 5'h13,
    OP_SUMROW = 5'h14,
    OP_SUMCOL = 5'h15
  } op_t;

  typedef enum logic [2:0] {
    SRC_REG    = 3'h0,
    SRC_SCALAR = 3'h1,
    SRC_IMM    = 3'h2,
    SRC_ROW    = 3'h3,
    SRC_COL    = 3'h4
  } opnd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MMUL = 2'b01
  } state_t;

  // Halfword product, sign or zero extended to the accumulator width.
  function automatic logic [39:0] mac_prod(input logic [31:0] a, input logic [31:0] b,
                                           input logic ahi, input logic bhi, input logic sgn);
    logic        [15:0] ha;
    logic        [15:0] hb;
    logic signed [16:0] sa;
    logic signed [16:0] sb;
    logic signed [33:0] p;
    ha = ahi ? a[31:16] : a[15:0];
    hb = bhi ? b[31:16] : b[15:0];
    sa = {sgn & ha[15], ha};
    sb = {sgn & hb[15], hb};
    p  = sa * sb;
    return {{6{p[33]}}, p};
  endfunction : mac_prod

endpackage : mat_pkg

// *** core/pe_alu.sv ***
// Element-wise arithmetic, logic, compare and halfword product of one processing element.
`timescale 1ns/1ps
`default_nettype none
module pe_alu (
  input  wire logic [4:0]  op_i,
  input  wire logic [31:0] a_i,
  input  wire logic [31:0] b_i,
  input  wire logic        half_i,
  input  wire logic        signed_i,
  input  wire logic [1:0]  hsel_i,
  output logic      [31:0] res_o,
  output logic      [3:0]  cc_o,
  output logic      [39:0] prod_o
);

  always_comb begin
    res_o = a_i;
    case (mat_pkg::op_t'(op_i))
      mat_pkg::OP_ADD: res_o = half_i ? {a_i[31:16] + b_i[31:16], a_i[15:0] + b_i[15:0]} : a_i + b_i;
      mat_pkg::OP_SUB: res_o = half_i ? {a_i[31:16] - b_i[31:16], a_i[15:0] - b_i[15:0]} : a_i - b_i;
      mat_pkg::OP_AND: res_o = a_i & b_i;
      mat_pkg::OP_OR:  res_o = a_i | b_i;
      mat_pkg::OP_XOR: res_o = a_i ^ b_i;
      default:         res_o = a_i;
    endcase
  end

  always_comb begin
    cc_o                 = 4'h0;
    cc_o[mat_pkg::CC_LT] = signed_i ? ($signed(a_i) < $signed(b_i)) : (a_i < b_i);
    cc_o[mat_pkg::CC_GT] = signed_i ? ($signed(a_i) > $signed(b_i)) : (a_i > b_i);
    cc_o[mat_pkg::CC_EQ] = (a_i == b_i);
    cc_o[mat_pkg::CC_NE] = (a_i != b_i);
  end

  assign prod_o = mat_pkg::mac_prod(a_i, b_i, hsel_i[1], hsel_i[0], signed_i);

endmodule : pe_alu
`default_nettype wire

// *** core/mat_engine.sv ***
// Instruction datapath of a 4x4 array of 32-bit processing elements.
// Summary of operation
// - Load or store moves a whole 64-byte matrix into or out of one register.
// - Add and subtract combine two matrices element by element into a destination.
// - Element operations take one cycle, on 32-bit words or two packed halfwords.
// - Compare each element against another register, a scalar or an immediate.
// - Most instructions accept a scalar or an immediate as second operand.
// - Multiply-accumulate uses upper or lower halfwords in any pairing.
// - Halfword operands are read as signed or unsigned per instruction.
// - Each product goes to one of two accumulators chosen by the instruction.
// - Movement instructions transpose, shift and rearrange blocks across registers.
// - Movement also offers table lookup and whole-row or whole-column shifts.
// - Computation moves data across the mesh, then adds, in overlapping stages.
// - Computation includes halfword matrix multiply and row or column sums.
// - Load puts sixteen consecutive words into a register in row order.
// - Four-register interleave spreads each source register across destination rows.
// - Matrix multiply does 128 halfword MACs in 4 cycles for 32 results, 16 in each accumulator.
// - Sixteen elements, each with sixteen 32-bit registers and two 40-bit accumulators.
// - Four condition codes per element gate results without branching.
// - An element may broadcast along its row or column as an operand.
`timescale 1ns/1ps
`default_nettype none
module mat_engine (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         instr_valid_i,
  output logic              instr_ready_o,
  input  wire logic [4:0]   op_i,
  input  wire logic [3:0]   dst_i,
  input  wire logic [3:0]   srca_i,
  input  wire logic [3:0]   srcb_i,
  input  wire logic [2:0]   opnd_sel_i,
  input  wire logic [1:0]   bidx_i,
  input  wire logic [31:0]  scalar_i,
  input  wire logic [15:0]  imm_i,
  input  wire logic         half_i,
  input  wire logic         signed_i,
  input  wire logic [1:0]   hsel_i,
  input  wire logic         acc_sel_i,
  input  wire logic         cc_en_i,
  input  wire logic [1:0]   cc_sel_i,
  input  wire logic [511:0] mem_rdata_i,
  output logic      [511:0] mem_wdata_o,
  output logic              mem_wvalid_o
);

  logic [31:0]       rf_r  [16][16];
  logic [39:0]       acc_r [2][16];
  logic [3:0]        cc_r  [16];
  logic [31:0]       a_w   [16];
  logic [31:0]       b_w   [16];
  logic [31:0]       res_w [16];
  logic [3:0]        pcc_w [16];
  logic [39:0]       prod_w[16];
  logic [31:0]       rf_nxt[16];
  logic [31:0]       mv_r  [16];
  logic [15:0]       en_w;
  mat_pkg::state_t   state_r;
  logic [1:0]        k_r;
  logic [3:0]        ma_r;
  logic [3:0]        mb_r;
  logic [1:0]        mh_r;
  logic              ms_r;
  logic              p2_v_r;
  logic              p2_col_r;
  logic [3:0]        p2_dst_r;
  logic              fire;
  logic [3:0]        amt;
  mat_pkg::op_t      op;

  assign op            = mat_pkg::op_t'(op_i);
  assign instr_ready_o = (state_r == mat_pkg::ST_IDLE);
  assign fire          = instr_valid_i && instr_ready_o;
  assign amt           = (opnd_sel_i == mat_pkg::SRC_IMM) ? imm_i[3:0] : scalar_i[3:0];

  always_comb begin
    for (int e = 0; e < 16; e++) begin
      a_w[e]  = rf_r[srca_i][e];
      en_w[e] = !cc_en_i || cc_r[e][cc_sel_i];
      case (mat_pkg::opnd_t'(opnd_sel_i))
        mat_pkg::SRC_SCALAR: b_w[e] = scalar_i;
        mat_pkg::SRC_IMM:    b_w[e] = signed_i ? {{16{imm_i[15]}}, imm_i} : {16'h0000, imm_i};
        mat_pkg::SRC_ROW:    b_w[e] = rf_r[srcb_i][(e / 4) * 4 + int'(bidx_i)];
        mat_pkg::SRC_COL:    b_w[e] = rf_r[srcb_i][int'(bidx_i) * 4 + (e % 4)];
        default:             b_w[e] = rf_r[srcb_i][e];
      endcase
    end
  end

  for (genvar g = 0; g < 16; g++) begin : g_pe
    pe_alu u_alu (
      .op_i     (op_i),
      .a_i      (a_w[g]),
      .b_i      (b_w[g]),
      .half_i   (half_i),
      .signed_i (signed_i),
      .hsel_i   (hsel_i),
      .res_o    (res_w[g]),
      .cc_o     (pcc_w[g]),
      .prod_o   (prod_w[g])
    );
  end

  always_comb begin
    for (int e = 0; e < 16; e++) begin
      case (op)
        mat_pkg::OP_LOAD:   rf_nxt[e] = mem_rdata_i[32 * e +: 32];
        mat_pkg::OP_ACCMOV: rf_nxt[e] = acc_r[acc_sel_i][e][31:0];
        mat_pkg::OP_TRANS:  rf_nxt[e] = a_w[(e % 4) * 4 + e / 4];
        mat_pkg::OP_SHIFT:  rf_nxt[e] = a_w[(e + int'(amt)) % 16];
        mat_pkg::OP_SHROW:  rf_nxt[e] = a_w[(((e / 4) + int'(amt)) % 4) * 4 + e % 4];
        mat_pkg::OP_SHCOL:  rf_nxt[e] = a_w[(e / 4) * 4 + ((e % 4) + int'(amt)) % 4];
        mat_pkg::OP_LOOKUP: rf_nxt[e] = a_w[b_w[e][3:0]];
        default:            rf_nxt[e] = res_w[e];
      endcase
    end
  end

  function automatic logic writes_rf(input mat_pkg::op_t o);
    return o inside {mat_pkg::OP_LOAD, mat_pkg::OP_ADD, mat_pkg::OP_SUB, mat_pkg::OP_AND, mat_pkg::OP_OR,
                     mat_pkg::OP_XOR, mat_pkg::OP_ACCMOV, mat_pkg::OP_TRANS, mat_pkg::OP_SHIFT,
                     mat_pkg::OP_SHROW, mat_pkg::OP_SHCOL, mat_pkg::OP_LOOKUP};
  endfunction : writes_rf

  // Matrix registers; the second compute stage writes last and so wins a same-register clash.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int r = 0; r < 16; r++) begin
        for (int e = 0; e < 16; e++) begin
          rf_r[r][e] <= mat_pkg::REG_RST;
        end
      end
    end else begin
      if (fire && writes_rf(op)) begin
        for (int e = 0; e < 16; e++) begin
          if (en_w[e]) begin
            rf_r[dst_i][e] <= rf_nxt[e];
          end
        end
      end
      if (fire && op == mat_pkg::OP_FOUR_REGISTER_BLOCK_INTERLEAVE) begin
        for (int r = 0; r < 4; r++) begin
          for (int e = 0; e < 16; e++) begin
            rf_r[{dst_i[3:2], 2'(r)}][e] <= rf_r[{srca_i[3:2], 2'(e / 4)}][r * 4 + e % 4];
          end
        end
      end
      if (p2_v_r) begin
        for (int e = 0; e < 16; e++) begin
          rf_r[p2_dst_r][e] <= mv_r[e] + mv_r[p2_col_r ? (e ^ 8) : (e ^ 2)];
        end
      end
    end
  end

  // First compute stage: pairwise move and add along rows or columns.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      p2_v_r   <= 1'b0;
      p2_col_r <= 1'b0;
      p2_dst_r <= 4'h0;
      for (int e = 0; e < 16; e++) begin
        mv_r[e] <= mat_pkg::REG_RST;
      end
    end else begin
      p2_v_r <= fire && (op == mat_pkg::OP_SUMROW || op == mat_pkg::OP_SUMCOL);
      if (fire) begin
        p2_col_r <= (op == mat_pkg::OP_SUMCOL);
        p2_dst_r <= dst_i;
        for (int e = 0; e < 16; e++) begin
          mv_r[e] <= a_w[e] + a_w[(op == mat_pkg::OP_SUMCOL) ? (e ^ 4) : (e ^ 1)];
        end
      end
    end
  end

  // Condition codes.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int e = 0; e < 16; e++) begin
        cc_r[e] <= mat_pkg::CC_RST;
      end
    end else if (fire && op == mat_pkg::OP_CMP) begin
      for (int e = 0; e < 16; e++) begin
        cc_r[e] <= pcc_w[e];
      end
    end
  end

  // Matrix multiply sequencer.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= mat_pkg::ST_IDLE;
      k_r     <= 2'h0;
      ma_r    <= 4'h0;
      mb_r    <= 4'h0;
      mh_r    <= 2'h0;
      ms_r    <= 1'b0;
    end else begin
      unique case (state_r)
        mat_pkg::ST_IDLE: begin
          k_r <= 2'h0;
          if (fire && op == mat_pkg::OP_MMUL) begin
            state_r <= mat_pkg::ST_MMUL;
            ma_r    <= srca_i;
            mb_r    <= srcb_i;
            mh_r    <= hsel_i;
            ms_r    <= signed_i;
          end
        end
        mat_pkg::ST_MMUL: begin
          k_r <= k_r + 2'h1;
          if (k_r == mat_pkg::MMUL_LAST) begin
            state_r <= mat_pkg::ST_IDLE;
          end
        end
        default: state_r <= mat_pkg::ST_IDLE;
      endcase
    end
  end

  // Accumulators; matrix multiply runs two halfword MACs per element per cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int e = 0; e < 16; e++) begin
        acc_r[0][e] <= mat_pkg::ACC_RST;
        acc_r[1][e] <= mat_pkg::ACC_RST;
      end
    end else if (state_r == mat_pkg::ST_MMUL) begin
      for (int e = 0; e < 16; e++) begin
        acc_r[0][e] <= ((k_r == 2'h0) ? mat_pkg::ACC_RST : acc_r[0][e]) + mat_pkg::mac_prod(
          rf_r[ma_r][(e / 4) * 4 + int'(k_r)], rf_r[mb_r][int'(k_r) * 4 + e % 4], mh_r[1], mh_r[0], ms_r);
        acc_r[1][e] <= ((k_r == 2'h0) ? mat_pkg::ACC_RST : acc_r[1][e]) + mat_pkg::mac_prod(
          rf_r[ma_r][(e / 4) * 4 + int'(k_r)], rf_r[mb_r][int'(k_r) * 4 + e % 4], !mh_r[1], !mh_r[0], ms_r);
      end
    end else if (fire && op inside {mat_pkg::OP_MUL, mat_pkg::OP_MAC, mat_pkg::OP_MSUB}) begin
      for (int e = 0; e < 16; e++) begin
        if (en_w[e]) begin
          unique case (op)
            mat_pkg::OP_MUL:  acc_r[acc_sel_i][e] <= prod_w[e];
            mat_pkg::OP_MAC:  acc_r[acc_sel_i][e] <= acc_r[acc_sel_i][e] + prod_w[e];
            mat_pkg::OP_MSUB: acc_r[acc_sel_i][e] <= acc_r[acc_sel_i][e] - prod_w[e];
          endcase
        end
      end
    end
  end

  // Store path.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_wdata_o  <= '0;
      mem_wvalid_o <= 1'b0;
    end else begin
      mem_wvalid_o <= fire && op == mat_pkg::OP_STORE;
      if (fire && op == mat_pkg::OP_STORE) begin
        for (int e = 0; e < 16; e++) begin
          mem_wdata_o[32 * e +: 32] <= a_w[e];
        end
      end
    end
  end

  // Checks.
  ready_stall_a: assert property (@(posedge clk_i) disable iff (rst_i) !instr_ready_o |=> !mem_wvalid_o && $stable(cc_r[0])) else $error("Instruction accepted while busy.");
  mmul_len_a: assert property (@(posedge clk_i) disable iff (rst_i) (fire && op == mat_pkg::OP_MMUL) |=> !instr_ready_o [*4] ##1 instr_ready_o) else $error("Matrix multiply length wrong.");
  load_order_a: assert property (@(posedge clk_i) disable iff (rst_i) (fire && op == mat_pkg::OP_LOAD && !cc_en_i && !p2_v_r && dst_i == 4'h2) |=> rf_r[2][5] == $past(mem_rdata_i[191:160])) else $error("Load element order wrong.");
  store_data_a: assert property (@(posedge clk_i) disable iff (rst_i) (fire && op == mat_pkg::OP_STORE) |=> mem_wvalid_o && mem_wdata_o[63:32] == $past(a_w[1])) else $error("Store data wrong.");
  add_elem_a: assert property (@(posedge clk_i) disable iff (rst_i) (fire && op == mat_pkg::OP_ADD && !half_i && !cc_en_i && !p2_v_r && dst_i == 4'h3) |=> rf_r[3][3] == $past(a_w[3]) + $past(b_w[3])) else $error("Element add wrong.");
  half_add_a: assert property (@(posedge clk_i) disable iff (rst_i) (fire && op == mat_pkg::OP_ADD && half_i && !cc_en_i && !p2_v_r && dst_i == 4'h3) |=> rf_r[3][0][15:0] == $past(a_w[0][15:0]) + $past(b_w[0][15:0])) else $error("Halfword add wrong.");
  cmp_eq_a: assert property (@(posedge clk_i) disable iff (rst_i) (fire && op == mat_pkg::OP_CMP) |=> cc_r[0][mat_pkg::CC_EQ] == ($past(a_w[0]) == $past(b_w[0]))) else $error("Compare flag wrong.");
  mac_acc_a: assert property (@(posedge clk_i) disable iff (rst_i) (fire && op == mat_pkg::OP_MAC && acc_sel_i && !cc_en_i) |=> acc_r[1][0] == $past(acc_r[1][0]) + $past(prod_w[0]) && $stable(acc_r[0][0])) else $error("Accumulate wrong.");
  trans_a: assert property (@(posedge clk_i) disable iff (rst_i) (fire && op == mat_pkg::OP_TRANS && !cc_en_i && !p2_v_r && dst_i == 4'hE) |=> rf_r[14][1] == $past(a_w[4])) else $error("Transpose wrong.");

endmodule : mat_engine
`default_nettype wire

// *** testbench/scalar_core_model.sv ***
// Scalar core model that presents matrix instructions and holds each until it is taken.
`timescale 1ns/1ps
`default_nettype none
module scalar_core_model (
  input  wire logic   clk_i,
  input  wire logic   instr_ready_i,
  output logic        instr_valid_o,
  output logic [4:0]  op_o,
  output logic [11:0] regs_o,
  output logic [2:0]  sel_o,
  output logic [31:0] scalar_o,
  output logic [15:0] imm_o,
  output logic [9:0]  flags_o
);
  initial begin
    instr_valid_o = 1'b0;
    op_o = 5'h00;
    regs_o = 12'h000;
    sel_o = 3'h0;
    scalar_o = 32'h0000_0000;
    imm_o = 16'h0000;
    flags_o = 10'h000;
  end

  // Fields change at the falling edge and stand until ready is seen at a falling edge and the next rising edge has passed.
  task automatic issue(input logic [4:0] op, input logic [11:0] r, input logic [2:0] s,
                       input logic [31:0] sc, input logic [15:0] im, input logic [9:0] f);
    int n;
    @(negedge clk_i);
    op_o = op;
    regs_o = r;
    sel_o = s;
    scalar_o = sc;
    imm_o = im;
    flags_o = f;
    instr_valid_o = 1'b1;
    n = 0;
    while (instr_ready_i !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    if (instr_ready_i !== 1'b1) begin
      test_matrix_engine_instruction_datapath.mismatches++;
      test_matrix_engine_instruction_datapath.test_done();
    end
    @(posedge clk_i);
  endtask : issue

  // Valid drops; the register, scalar and immediate fields are inverted so they no longer show the last value.
  task automatic idle;
    @(negedge clk_i);
    instr_valid_o = 1'b0;
    regs_o = ~regs_o;
    scalar_o = ~scalar_o;
    imm_o = ~imm_o;
  endtask : idle
endmodule : scalar_core_model
`default_nettype wire

// *** testbench/test_matrix_engine_instruction_datapath.sv ***
// Self-checking testbench of the matrix engine datapath.
`timescale 1ns/1ps
`default_nettype none
module test_matrix_engine_instruction_datapath;
  logic         clk_i;
  logic         rst_i;
  logic         valid;
  logic         instr_ready_o;
  logic [4:0]   op;
  logic [11:0]  rg;
  logic [2:0]   sel;
  logic [31:0]  sc;
  logic [15:0]  im;
  logic [9:0]   fl;
  logic [511:0] mem_rdata_i;
  logic [511:0] mem_wdata_o;
  logic         mem_wvalid_o;
  int           mismatches = 0;
  int           n_compared = 0;

  scalar_core_model core (.clk_i(clk_i), .instr_ready_i(instr_ready_o), .instr_valid_o(valid), .op_o(op),
                          .regs_o(rg), .sel_o(sel), .scalar_o(sc), .imm_o(im), .flags_o(fl));
  mat_engine dut (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(valid), .instr_ready_o(instr_ready_o),
                  .op_i(op), .dst_i(rg[11:8]), .srca_i(rg[7:4]), .srcb_i(rg[3:0]), .opnd_sel_i(sel),
                  .bidx_i(fl[9:8]), .scalar_i(sc), .imm_i(im), .half_i(fl[7]), .signed_i(fl[6]),
                  .hsel_i(fl[5:4]), .acc_sel_i(fl[3]), .cc_en_i(fl[2]), .cc_sel_i(fl[1:0]),
                  .mem_rdata_i(mem_rdata_i), .mem_wdata_o(mem_wdata_o), .mem_wvalid_o(mem_wvalid_o));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] m(input int s, input int e);
    return 32'(32'h9E37_79B9 * (s * 16 + e + 1));
  endfunction : m

  function automatic logic [511:0] mv(input int s);
    logic [511:0] v;
    for (int e = 0; e < 16; e++) v[32*e +: 32] = m(s, e);
    return v;
  endfunction : mv

  // Halfword product extended to the accumulator width.
  function automatic logic [39:0] hp(input logic [31:0] a, input logic [31:0] b,
                                     input logic ah, input logic bh, input logic sg);
    logic [15:0] x;
    logic [15:0] y;
    logic [39:0] u;
    logic [39:0] w;
    x = ah ? a[31:16] : a[15:0];
    y = bh ? b[31:16] : b[15:0];
    u = {{24{sg & x[15]}}, x};
    w = {{24{sg & y[15]}}, y};
    return u * w;
  endfunction : hp

  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask : cmp1

  task automatic cmp512(input logic [511:0] got, input logic [511:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask : cmp512

  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic run(input logic [4:0] o, input logic [11:0] r, input logic [2:0] s,
                     input logic [31:0] c, input logic [15:0] i, input logic [9:0] f);
    core.issue(o, r, s, c, i, f);
    core.idle();
  endtask : run

  task automatic ld(input logic [3:0] r, input logic [511:0] v);
    @(negedge clk_i);
    mem_rdata_i = v;
    run(mat_pkg::OP_LOAD, {r, 8'h00}, mat_pkg::SRC_REG, 32'h0, 16'h0, 10'h000);
    mem_rdata_i = ~v;
  endtask : ld

  // Stores a register and checks that the write valid is high and the whole matrix matches in the cycle after.
  task automatic st(input logic [3:0] r, input logic [511:0] x);
    core.issue(mat_pkg::OP_STORE, {r, r, r}, mat_pkg::SRC_REG, 32'h0, 16'h0, 10'h000);
    core.idle();
    cmp1(mem_wvalid_o, 1'b1);
    cmp512(mem_wdata_o, x);
  endtask : st

  task automatic sc_arith;
    logic [511:0] x [4];
    logic [31:0]  t;
    for (int e = 0; e < 16; e++) begin
      t = m(1, e);
      x[0][32*e +: 32] = t + m(2, e);
      x[1][32*e +: 32] = {t[31:16] - 16'h1234, t[15:0] - 16'h5678};
      x[2][32*e +: 32] = {t[31:16] - 16'h0001, t[15:0] - 16'h0001};
      x[3][32*e +: 32] = t ^ 32'hA5A5_5A5A;
    end
    run(mat_pkg::OP_ADD, 12'h312, mat_pkg::SRC_REG, 32'h0, 16'h0, 10'h000);
    st(4'd3, x[0]);
    run(mat_pkg::OP_SUB, 12'h310, mat_pkg::SRC_SCALAR, 32'h1234_5678, 16'h0, 10'h080);
    st(4'd3, x[1]);
    run(mat_pkg::OP_ADD, 12'h310, mat_pkg::SRC_IMM, 32'h0, 16'hFFFF, 10'h0C0);
    st(4'd3, x[2]);
    run(mat_pkg::OP_XOR, 12'h310, mat_pkg::SRC_SCALAR, 32'hA5A5_5A5A, 16'h0, 10'h000);
    st(4'd3, x[3]);
  endtask : sc_arith

  task automatic sc_cmp;
    logic [511:0] x [3];
    x[0] = '0;
    x[1] = mv(1);
    for (int e = 0; e < 16; e++) begin
      x[2][32*e +: 32] = (m(1, e) < m(1, 5)) ? m(1, e) : 32'h0;
    end
    x[0][32*5 +: 32] = m(1, 5);
    x[1][32*5 +: 32] = 32'h0;
    run(mat_pkg::OP_CMP, 12'h010, mat_pkg::SRC_SCALAR, m(1, 5), 16'h0, 10'h000);
    run(mat_pkg::OP_ADD, 12'hC10, mat_pkg::SRC_REG, 32'h0, 16'h0, 10'h006);
    st(4'd12, x[0]);
    run(mat_pkg::OP_ADD, 12'hD10, mat_pkg::SRC_REG, 32'h0, 16'h0, 10'h004);
    st(4'd13, x[1]);
    run(mat_pkg::OP_ADD, 12'hB10, mat_pkg::SRC_REG, 32'h0, 16'h0, 10'h007);
    st(4'd11, x[2]);
  endtask : sc_cmp

  task automatic sc_mac;
    logic [511:0] x;
    logic [39:0]  p;
    logic [9:0]   f;
    for (int i = 0; i < 8; i++) begin
      for (int e = 0; e < 16; e++) begin
        p = hp(m(1, e), m(2, e), i[1], i[0], i[2]);
        x[32*e +: 32] = 32'(p + p);
      end
      f = {3'h0, i[2], i[1], i[0], 4'h8};
      run(mat_pkg::OP_MUL, 12'h012, mat_pkg::SRC_REG, 32'h0, 16'h0, f);
      run(mat_pkg::OP_MAC, 12'h012, mat_pkg::SRC_REG, 32'h0, 16'h0, f);
      run(mat_pkg::OP_MAC, 12'h012, mat_pkg::SRC_REG, 32'h0, 16'h0, f);
      run(mat_pkg::OP_MSUB, 12'h012, mat_pkg::SRC_REG, 32'h0, 16'h0, f);
      run(mat_pkg::OP_ACCMOV, 12'hE00, mat_pkg::SRC_REG, 32'h0, 16'h0, f);
      st(4'd14, x);
    end
  endtask : sc_mac

  task automatic sc_move;
    logic [511:0] x;
    logic [31:0]  s;
    logic [31:0]  u;
    logic [4:0]   o;
    logic [2:0]   sl;
    for (int k = 0; k < 9; k++) begin
      for (int e = 0; e < 16; e++) begin
        s = 32'h0;
        u = 32'h0;
        for (int c = 0; c < 4; c++) begin
          s = s + m(1, (e / 4) * 4 + c);
          u = u + m(1, c * 4 + e % 4);
        end
        case (k)
          0: x[32*e +: 32] = m(1, (e % 4) * 4 + e / 4);
          1: x[32*e +: 32] = m(1, (e + 3) % 16);
          2: x[32*e +: 32] = m(1, ((e / 4 + 1) % 4) * 4 + e % 4);
          3: x[32*e +: 32] = m(1, int'(m(2, e) & 32'hF));
          4: x[32*e +: 32] = s;
          5: x[32*e +: 32] = m(1, (e / 4) * 4 + (e % 4 + 1) % 4);
          6: x[32*e +: 32] = u;
          7: x[32*e +: 32] = m(1, e) + m(2, (e / 4) * 4 + 1);
          default: x[32*e +: 32] = m(1, e) + m(2, 4 + e % 4);
        endcase
      end
      case (k)
        0: {o, sl} = {mat_pkg::OP_TRANS, mat_pkg::SRC_REG};
        1: {o, sl} = {mat_pkg::OP_SHIFT, mat_pkg::SRC_IMM};
        2: {o, sl} = {mat_pkg::OP_SHROW, mat_pkg::SRC_SCALAR};
        3: {o, sl} = {mat_pkg::OP_LOOKUP, mat_pkg::SRC_REG};
        4: {o, sl} = {mat_pkg::OP_SUMROW, mat_pkg::SRC_REG};
        5: {o, sl} = {mat_pkg::OP_SHCOL, mat_pkg::SRC_SCALAR};
        6: {o, sl} = {mat_pkg::OP_SUMCOL, mat_pkg::SRC_REG};
        7: {o, sl} = {mat_pkg::OP_ADD, mat_pkg::SRC_ROW};
        default: {o, sl} = {mat_pkg::OP_ADD, mat_pkg::SRC_COL};
      endcase
      run(o, 12'hE12, sl, 32'h1, 16'h3, 10'h100);
      if (k == 4 || k == 6) @(negedge clk_i);
      st(4'd14, x);
    end
  endtask : sc_move

  task automatic sc_four_register_block_interleave;
    logic [511:0] x;
    run(mat_pkg::OP_FOUR_REGISTER_BLOCK_INTERLEAVE, 12'h840, mat_pkg::SRC_REG, 32'h0, 16'h0, 10'h000);
    for (int r = 0; r < 4; r++) begin
      for (int q = 0; q < 4; q++) begin
        for (int c = 0; c < 4; c++) x[32*(4*q+c) +: 32] = m(4 + q, 4 * r + c);
      end
      st(4'(8 + r), x);
    end
  endtask : sc_four_register_block_interleave

  task automatic sc_mmul;
    logic [511:0] x [2];
    logic [39:0]  p;
    for (int a = 0; a < 2; a++) begin
      for (int e = 0; e < 16; e++) begin
        p = 40'h0;
        for (int k = 0; k < 4; k++) p = p + hp(m(1, (e / 4) * 4 + k), m(2, k * 4 + e % 4), a == 0, a == 1, 1'b1);
        x[a][32*e +: 32] = p[31:0];
      end
    end
    core.issue(mat_pkg::OP_MMUL, 12'h012, mat_pkg::SRC_REG, 32'h0, 16'h0, 10'h060);
    core.idle();
    cmp1(instr_ready_o, 1'b0);
    for (int c = 2; c < 6; c++) begin
      @(negedge clk_i);
      cmp1(instr_ready_o, c == 5);
    end
    for (int a = 0; a < 2; a++) begin
      run(mat_pkg::OP_ACCMOV, 12'hF00, mat_pkg::SRC_REG, 32'h0, 16'h0, {6'h00, a[0], 3'h0});
      st(4'd15, x[a]);
    end
    // An instruction offered during the multiply must wait until the multiply has finished.
    core.issue(mat_pkg::OP_MMUL, 12'h012, mat_pkg::SRC_REG, 32'h0, 16'h0, 10'h060);
    run(mat_pkg::OP_ACCMOV, 12'h000, mat_pkg::SRC_REG, 32'h0, 16'h0, 10'h000);
    st(4'd0, x[0]);
  endtask : sc_mmul

  initial begin
    rst_i = 1'b1;
    mem_rdata_i = '0;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    st(4'd0, '0);
    for (int s = 1; s < 8; s++) ld(4'(s), mv(s));
    st(4'd1, mv(1));
    sc_arith();
    sc_cmp();
    sc_mac();
    sc_move();
    sc_four_register_block_interleave();
    sc_mmul();
    test_done();
  end
endmodule : test_matrix_engine_instruction_datapath
`default_nettype wire
